// ===== logic/ps2s_params.svh
`ifndef PS2S_PARAMS_SVH
`define PS2S_PARAMS_SVH
// register byte offsets
`define PS2S_OFF_DATA 5'h00
`define PS2S_OFF_CTRL 5'h04
`define PS2S_OFF_STAT 5'h08
`define PS2S_OFF_INT_STAT 5'h0C
`define PS2S_OFF_INT_MASK 5'h10
// status bit positions
`define PS2S_ST_LATE 7
`define PS2S_ST_TIMEOUT 5
`define PS2S_ST_STOP_ERR 3
`define PS2S_ST_RX_ERR 1
// control field positions
`define PS2S_CT_DIR 0
`define PS2S_CT_ON 1
`define PS2S_CT_PAR_LO 2
`define PS2S_CT_STOP_LO 4
// stop level encodings
`define PS2S_STOP_HIGH 2'h0
`define PS2S_STOP_LOW 2'h1
// reset values
`define PS2S_TXQ_RST 1'h1
`define PS2S_PIN_LOW_RST 1'h1
// timing figures and link frame counts
`define PS2S_CLK_HZ 40000000
`define PS2S_START_LATE_MS 25
`define PS2S_BIT_GAP_US 300
`define PS2S_FRAME_MS 2
`define PS2S_HOLD_US 300
`define PS2S_LAST_EDGE 4'hA
`endif

// ===== logic/ps2s_pkg.sv
package ps2s_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT_START, TX_SHIFT} ps2s_tx_state_t;
	typedef enum logic {RX_IDLE, RX_FRAME} ps2s_rx_state_t;
	// control register fields, also handed to the shifter
	typedef struct packed {
		logic [1:0] stop_level;
		logic [1:0] parity;
		logic channel_on;
		logic direction_select;
	} ps2s_ctrl_t;
	// status flags kept by this block
	typedef struct packed {
		logic tx_start_late_flag;
		logic rx_active;
		logic tx_timeout_flag;
		logic tx_quiet;
		logic stop_bit_error;
		logic rx_error_flag;
	} ps2s_flags_t;
	// whole state of the channel status block
	typedef struct packed {
		logic clk_s1;
		logic clk_s2;
		logic clk_prev;
		logic dat_s1;
		logic dat_s2;
		ps2s_ctrl_t ctrl;
		ps2s_flags_t flags;
		ps2s_tx_state_t tx_state;
		ps2s_rx_state_t rx_state;
		logic [3:0] tx_edges;
		logic [3:0] rx_edges;
		logic [19:0] tmr;
		logic [16:0] frame_tmr;
		logic [13:0] hold_tmr;
		logic clk_low;
		logic read_seen;
		logic pin_low;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic ack;
		logic [31:0] rdata;
		logic [7:0] tx_data;
		logic tx_load;
	} ps2s_state_t;
endpackage

// ===== logic/ps2s_status.sv
// Summary of operation
// - start bit over 25 ms late sets flag
// - late start also sets transmit timeout
// - receive-active bit shows frame in progress
// - timeout forces receive, holds clock low
// - bit gap over 300us is timeout
// - start to tenth bit over 2ms: timeout
// - transmit buffer write clears tx_quiet
// - eleventh edge, timeout, control clears set quiet
// - rising tx_quiet raises activity interrupt
// - wrong stop level sets error flags
// - receive error holds clock low too
// - stop config: high, low or ignored
//
// Chosen here: the Avalon-MM interface to the registers.
`include "ps2s_params.svh"
module ps2s_status #(
	parameter int unsigned START_LATE_CYC = `PS2S_START_LATE_MS * (`PS2S_CLK_HZ / 1000),
	parameter int unsigned GAP_CYC = `PS2S_BIT_GAP_US * (`PS2S_CLK_HZ / 1000000),
	parameter int unsigned FRAME_CYC = `PS2S_FRAME_MS * (`PS2S_CLK_HZ / 1000),
	parameter int unsigned HOLD_CYC = `PS2S_HOLD_US * (`PS2S_CLK_HZ / 1000000)
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic ps2_clk_i,
	input wire logic ps2_data_i,
	output logic ps2_clk_o,
	output logic ps2_clk_oe_o,
	input wire logic rx_fault_i,
	output logic [7:0] tx_data_o,
	output logic tx_load_o,
	output ps2s_pkg::ps2s_ctrl_t ctrl_o,
	output logic irq_o
);
	ps2s_pkg::ps2s_state_t st_reg; // registered state
	ps2s_pkg::ps2s_state_t st_next; // next state
	logic req; // bus request present
	logic acc; // request taken this edge
	logic wr_acc; // write taken
	logic rd_stat; // status register read taken
	logic fall; // link clock falling edge, own hold masked
	logic rx_on; // receiver may watch the link
	logic stop_bad; // sampled stop level is wrong

	// status word as software sees it; parity and data-ready live in the shifter
	function automatic logic [31:0] status_word(input ps2s_pkg::ps2s_flags_t f);
		status_word = {24'h000000, f.tx_start_late_flag, f.rx_active, f.tx_timeout_flag,
			f.tx_quiet, f.stop_bit_error, 1'b0, f.rx_error_flag, 1'b0};
	endfunction

	// one wait cycle on every access keeps read data from a flop
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~st_reg.ack;
	assign acc = req & st_reg.ack;
	assign wr_acc = acc & avs_write_i & avs_byteenable_i[0];
	assign rd_stat = acc & avs_read_i & (avs_address_i == `PS2S_OFF_STAT);
	// our own pull-down would look like a peripheral edge, so it is masked
	assign fall = st_reg.clk_prev & ~st_reg.clk_s2 & ~st_reg.clk_low;
	assign rx_on = st_reg.ctrl.channel_on & ~st_reg.ctrl.direction_select & ~st_reg.clk_low;
	// ignored or reserved encodings never flag an error
	assign stop_bad = ((st_reg.ctrl.stop_level == `PS2S_STOP_HIGH) & ~st_reg.dat_s2) |
		((st_reg.ctrl.stop_level == `PS2S_STOP_LOW) & st_reg.dat_s2);

	// outputs from the state flops; clock output tied low, irq gated by the mask
	assign avs_readdata_o = st_reg.rdata;
	assign ps2_clk_o = 1'b0;
	assign ps2_clk_oe_o = st_reg.pin_low;
	assign tx_data_o = st_reg.tx_data;
	assign tx_load_o = st_reg.tx_load;
	assign ctrl_o = st_reg.ctrl;
	assign irq_o = |(st_reg.int_stat & st_reg.int_mask);

	// next-state logic for the whole block
	always_comb
	begin
		st_next = st_reg;
		st_next.tx_load = 1'b0;
		// two-flop synchronisers, third stage for edge finding
		st_next.clk_s1 = ps2_clk_i;
		st_next.clk_s2 = st_reg.clk_s1;
		st_next.clk_prev = st_reg.clk_s2;
		st_next.dat_s1 = ps2_data_i;
		st_next.dat_s2 = st_reg.dat_s1;
		st_next.ack = req & ~st_reg.ack;
		// read data captured in the wait cycle
		if (req & ~st_reg.ack & avs_read_i)
		begin
			if (avs_address_i == `PS2S_OFF_STAT)
			begin
				st_next.rdata = status_word(st_reg.flags);
			end
			else if (avs_address_i == `PS2S_OFF_CTRL)
			begin
				st_next.rdata = {26'h0000000, st_reg.ctrl};
			end
			else if (avs_address_i == `PS2S_OFF_INT_STAT)
			begin
				st_next.rdata = {29'h00000000, st_reg.int_stat};
			end
			else if (avs_address_i == `PS2S_OFF_INT_MASK)
			begin
				st_next.rdata = {29'h00000000, st_reg.int_mask};
			end
			else
			begin
				// receive buffer lives in the shifter; unmapped reads zero
				st_next.rdata = 32'h00000000;
			end
		end
		// interrupt status clears on read, before new events land
		if (acc & avs_read_i & (avs_address_i == `PS2S_OFF_INT_STAT))
		begin
			st_next.int_stat = 3'h0;
		end
		// register writes
		if (wr_acc)
		begin
			if (avs_address_i == `PS2S_OFF_DATA)
			begin
				// only an armed, enabled, idle transmitter starts
				if (st_reg.ctrl.channel_on & st_reg.ctrl.direction_select &
					(st_reg.tx_state == ps2s_pkg::TX_IDLE))
				begin
					st_next.tx_data = avs_writedata_i[7:0];
					st_next.tx_load = 1'b1;
					st_next.flags.tx_quiet = 1'b0;
					st_next.tx_state = ps2s_pkg::TX_WAIT_START;
					st_next.tmr = 20'h00000;
				end
			end
			else if (avs_address_i == `PS2S_OFF_CTRL)
			begin
				st_next.ctrl.stop_level = avs_writedata_i[`PS2S_CT_STOP_LO +: 2];
				st_next.ctrl.parity = avs_writedata_i[`PS2S_CT_PAR_LO +: 2];
				st_next.ctrl.channel_on = avs_writedata_i[`PS2S_CT_ON];
				// held in receive while the timeout flag stands
				st_next.ctrl.direction_select = avs_writedata_i[`PS2S_CT_DIR] &
					~st_reg.flags.tx_timeout_flag;
				// dropping either bit ends any transmission
				if (~st_next.ctrl.channel_on | ~st_next.ctrl.direction_select)
				begin
					st_next.tx_state = ps2s_pkg::TX_IDLE;
					st_next.flags.tx_quiet = 1'b1;
				end
			end
			else if (avs_address_i == `PS2S_OFF_STAT)
			begin
				// write one to clear; zeros leave flags alone
				if (avs_writedata_i[`PS2S_ST_LATE])
				begin
					st_next.flags.tx_start_late_flag = 1'b0;
				end
				if (avs_writedata_i[`PS2S_ST_TIMEOUT])
				begin
					st_next.flags.tx_timeout_flag = 1'b0;
				end
				if (avs_writedata_i[`PS2S_ST_STOP_ERR])
				begin
					st_next.flags.stop_bit_error = 1'b0;
				end
				if (avs_writedata_i[`PS2S_ST_RX_ERR])
				begin
					st_next.flags.rx_error_flag = 1'b0;
				end
			end
			else if (avs_address_i == `PS2S_OFF_INT_MASK)
			begin
				st_next.int_mask = avs_writedata_i[2:0];
			end
		end
		// transmit watch: hardware sets come after clears so a set wins
		case (st_reg.tx_state)
			ps2s_pkg::TX_WAIT_START:
			begin
				if (st_next.tx_state == ps2s_pkg::TX_WAIT_START)
				begin
					st_next.tmr = st_reg.tmr + 20'h00001;
					if (fall)
					begin
						// start bit seen: bit and frame timers begin
						st_next.tx_state = ps2s_pkg::TX_SHIFT;
						st_next.tx_edges = 4'h1;
						st_next.tmr = 20'h00000;
						st_next.frame_tmr = 17'h00000;
					end
					else if (32'(st_reg.tmr) > START_LATE_CYC)
					begin
						st_next.flags.tx_start_late_flag = 1'b1;
						st_next.flags.tx_timeout_flag = 1'b1;
					end
				end
			end
			ps2s_pkg::TX_SHIFT:
			begin
				if (st_next.tx_state == ps2s_pkg::TX_SHIFT)
				begin
					st_next.tmr = st_reg.tmr + 20'h00001;
					st_next.frame_tmr = st_reg.frame_tmr + 17'h00001;
					if (fall)
					begin
						st_next.tmr = 20'h00000;
						st_next.tx_edges = st_reg.tx_edges + 4'h1;
						if (st_reg.tx_edges == `PS2S_LAST_EDGE)
						begin
							// eleventh edge ends the frame; software re-arms
							st_next.tx_state = ps2s_pkg::TX_IDLE;
							st_next.flags.tx_quiet = 1'b1;
							st_next.ctrl.direction_select = 1'b0;
						end
					end
					else if (32'(st_reg.tmr) > GAP_CYC)
					begin
						st_next.flags.tx_timeout_flag = 1'b1;
					end
					else if ((st_reg.tx_edges < `PS2S_LAST_EDGE) & (32'(st_reg.frame_tmr) > FRAME_CYC))
					begin
						st_next.flags.tx_timeout_flag = 1'b1;
					end
				end
			end
			default:
			begin
			end
		endcase
		// any new transmit timeout aborts and returns to receive
		if (st_next.flags.tx_timeout_flag & ~st_reg.flags.tx_timeout_flag)
		begin
			st_next.tx_state = ps2s_pkg::TX_IDLE;
			st_next.flags.tx_quiet = 1'b1;
			st_next.ctrl.direction_select = 1'b0;
		end
		// receive frame tracking
		case (st_reg.rx_state)
			ps2s_pkg::RX_IDLE:
			begin
				if (rx_on & fall & ~st_reg.dat_s2)
				begin
					st_next.rx_state = ps2s_pkg::RX_FRAME;
					st_next.rx_edges = 4'h1;
				end
			end
			ps2s_pkg::RX_FRAME:
			begin
				if (~rx_on)
				begin
					st_next.rx_state = ps2s_pkg::RX_IDLE;
				end
				else if (fall)
				begin
					st_next.rx_edges = st_reg.rx_edges + 4'h1;
					if (st_reg.rx_edges == `PS2S_LAST_EDGE)
					begin
						// stop bit sampled on the eleventh falling edge
						st_next.rx_state = ps2s_pkg::RX_IDLE;
						if (stop_bad)
						begin
							st_next.flags.stop_bit_error = 1'b1;
							st_next.flags.rx_error_flag = 1'b1;
						end
					end
				end
			end
			default:
			begin
				st_next.rx_state = ps2s_pkg::RX_IDLE;
			end
		endcase
		// shifter reports parity and receive timing faults here
		if (rx_fault_i)
		begin
			st_next.flags.rx_error_flag = 1'b1;
		end
		st_next.flags.rx_active = (st_next.rx_state == ps2s_pkg::RX_FRAME);
		// clock hold: at least the minimum, then until status is read
		if (st_reg.clk_low)
		begin
			if (st_reg.hold_tmr != 14'h3FFF)
			begin
				st_next.hold_tmr = st_reg.hold_tmr + 14'h0001;
			end
			if (rd_stat)
			begin
				st_next.read_seen = 1'b1;
			end
			if ((32'(st_reg.hold_tmr) >= HOLD_CYC) & (st_reg.read_seen | rd_stat))
			begin
				st_next.clk_low = 1'b0;
			end
		end
		// a fresh error restarts the hold
		if ((st_next.flags.tx_timeout_flag & ~st_reg.flags.tx_timeout_flag) |
			(st_next.flags.rx_error_flag & ~st_reg.flags.rx_error_flag))
		begin
			st_next.clk_low = 1'b1;
			st_next.hold_tmr = 14'h0000;
			st_next.read_seen = 1'b0;
		end
		// disabled channel also drives the clock low
		st_next.pin_low = st_next.clk_low | ~st_next.ctrl.channel_on;
		// sticky interrupt events
		if (st_next.flags.tx_quiet & ~st_reg.flags.tx_quiet)
		begin
			st_next.int_stat[0] = 1'b1;
		end
		if (st_next.flags.rx_error_flag & ~st_reg.flags.rx_error_flag)
		begin
			st_next.int_stat[1] = 1'b1;
		end
		if (st_next.flags.stop_bit_error & ~st_reg.flags.stop_bit_error)
		begin
			st_next.int_stat[2] = 1'b1;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			st_reg <= '0;
			st_reg.flags.tx_quiet <= `PS2S_TXQ_RST;
			st_reg.pin_low <= `PS2S_PIN_LOW_RST;
		end
		else if (ce_i)
		begin
			st_reg <= st_next;
		end
	end

	// a late start always reports a transmit timeout too
	AST_LATE_WITH_TIMEOUT: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(st_reg.flags.tx_start_late_flag) |-> st_reg.flags.tx_timeout_flag)
		else $error("late start without transmit timeout");

	AST_LATE_FROM_WAIT: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(st_reg.flags.tx_start_late_flag) |-> $past(st_reg.tx_state) == ps2s_pkg::TX_WAIT_START
			&& 32'($past(st_reg.tmr)) > START_LATE_CYC)
		else $error("late start flagged outside start wait");

	AST_RX_BUSY_ON_START: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(st_reg.flags.rx_active) |-> $past(fall) && !$past(st_reg.dat_s2))
		else $error("receive busy without start bit");

	AST_TIMEOUT_HOLDS: assert property (@(posedge clk_i) disable iff (reset_i)
		st_reg.flags.tx_timeout_flag |-> !st_reg.ctrl.direction_select
			&& (st_reg.tx_state == ps2s_pkg::TX_IDLE))
		else $error("transmit allowed while timeout stands");

	AST_HOLD_PIN: assert property (@(posedge clk_i) disable iff (reset_i)
		($rose(st_reg.flags.rx_error_flag) || $rose(st_reg.flags.tx_timeout_flag)) |->
			st_reg.clk_low ##1 (!ce_i || st_reg.pin_low))
		else $error("clock not pulled low after error");

	AST_HOLD_MIN: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(st_reg.clk_low) |-> 32'($past(st_reg.hold_tmr)) >= HOLD_CYC && $past(st_reg.read_seen || rd_stat))
		else $error("clock hold released early");

	AST_GAP_BOUND: assert property (@(posedge clk_i) disable iff (reset_i)
		st_reg.tx_state == ps2s_pkg::TX_SHIFT |-> 32'(st_reg.tmr) <= GAP_CYC + 1)
		else $error("bit gap exceeded without timeout");

	AST_FRAME_BOUND: assert property (@(posedge clk_i) disable iff (reset_i)
		st_reg.tx_state == ps2s_pkg::TX_SHIFT && st_reg.tx_edges < `PS2S_LAST_EDGE |->
			32'(st_reg.frame_tmr) <= FRAME_CYC + 1)
		else $error("frame time exceeded without timeout");

	AST_TXBUF_CLEARS_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_acc && avs_address_i == `PS2S_OFF_DATA && st_reg.ctrl.channel_on
			&& st_reg.ctrl.direction_select && st_reg.tx_state == ps2s_pkg::TX_IDLE |=>
			!st_reg.flags.tx_quiet && tx_load_o)
		else $error("transmit buffer write did not start");

	AST_QUIET_AFTER_ELEVENTH: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && st_reg.tx_state == ps2s_pkg::TX_SHIFT && fall && st_reg.tx_edges == `PS2S_LAST_EDGE |=>
			st_reg.flags.tx_quiet && !st_reg.ctrl.direction_select)
		else $error("eleventh edge did not end transmission");

	AST_QUIET_IRQ: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(st_reg.flags.tx_quiet) |-> st_reg.int_stat[0])
		else $error("quiet rise without activity event");

	AST_STOP_CHECK: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(st_reg.flags.stop_bit_error) |-> st_reg.flags.rx_error_flag
			&& ($past(st_reg.ctrl.stop_level) == `PS2S_STOP_HIGH || $past(st_reg.ctrl.stop_level) == `PS2S_STOP_LOW))
		else $error("stop error with level ignored");

	AST_W1C_LATE: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_acc && avs_address_i == `PS2S_OFF_STAT && avs_writedata_i[`PS2S_ST_LATE]
			&& st_reg.tx_state != ps2s_pkg::TX_WAIT_START |=> !st_reg.flags.tx_start_late_flag)
		else $error("start-late flag not cleared by write one");
endmodule

// ===== verif/ps2s_peer.sv
module ps2s_peer (
	output logic clk_low_o,
	output logic dat_low_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// released lines float to the pull-up, never to the last level
	initial
	begin
		clk_low_o = 1'h0;
		dat_low_o = 1'h0;
	end
	// n falling edges, data set while clock high, lsb first
	task automatic pulse(input int n, input int half_ns, input logic [10:0] bits);
		#7; // phase unrelated to the system clock
		for (int i = 0; i < n; i++)
		begin
			dat_low_o = ~bits[i];
			#(half_ns) clk_low_o = 1'h1;
			#(half_ns) clk_low_o = 1'h0;
		end
		dat_low_o = 1'h0; // data released between frames
	endtask
endmodule

// ===== verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned LATE = 400;
	localparam int unsigned GAP = 60;
	localparam int unsigned FRM = 400;
	localparam int unsigned HOLD = 20;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hF;
	logic fault = 1'h0;
	logic ce = 1'h1;
	logic [31:0] rdat;
	logic wait_o;
	logic clk_o;
	logic clk_oe;
	logic [7:0] txd;
	logic txl;
	ps2s_pkg::ps2s_ctrl_t ctrl;
	logic irq;
	logic m_clk_low;
	logic m_dat_low;
	int bad_count = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h7440E15A;
	logic [31:0] v;
	logic [31:0] q;
	logic [31:0] ex;
	logic e;
	// open-drain wire: low if either side pulls
	wire line_clk = ~((clk_oe & ~clk_o) | m_clk_low);
	wire line_dat = ~m_dat_low;
	always #12.5 clk_i = ~clk_i;
	ps2s_status #(.START_LATE_CYC(LATE), .GAP_CYC(GAP), .FRAME_CYC(FRM), .HOLD_CYC(HOLD)) ps2s_status_inst (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_o), .ps2_clk_i(line_clk), .ps2_data_i(line_dat), .ps2_clk_o(clk_o),
		.ps2_clk_oe_o(clk_oe), .rx_fault_i(fault), .tx_data_o(txd), .tx_load_o(txl), .ctrl_o(ctrl), .irq_o(irq)
	);
	ps2s_peer ps2s_peer_inst (.clk_low_o(m_clk_low), .dat_low_o(m_dat_low));
	// xorshift source, fixed seed keeps runs repeatable
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// start 0, data lsb first, odd parity, stop
	function automatic logic [10:0] frame_bits(input logic [7:0] b, input logic stop);
		return {stop, ~^b, b, 1'h0};
	endfunction
	// stop mismatch only for the high and low settings
	function automatic logic stop_bad(input logic [1:0] code, input logic stop);
		return (code == 2'h0 && !stop) || (code == 2'h1 && stop);
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
		int n;
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		be <= b;
		rd <= ~w;
		wr <= w;
		n = 0;
		// no cycle limit here: only the watchdog ends a hung access
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wait_o !== 1'h0);
		q = rdat;
		// one wait cycle on every access while the clock enable is high
		check("wait_cycles", n, 32'h2);
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	task automatic bw(input logic [4:0] a, input logic [31:0] d);
		bus(1'h1, a, d, 4'hF);
	endtask
	task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0, 4'hF);
		check(nm, q, exp);
	endtask
	// watchdog sized well above the expected run
	initial
	begin
		#1000000;
		bad_count++;
		results();
	end
	initial
	begin
		cyc(2);
		reset_i <= 1'h0;
		rc("stat", 5'h08, 32'h10);
		rc("ctrl", 5'h04, 32'h0);
		rc("unmapped", 5'h14, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		$display("test reset done");
		bw(5'h10, 32'h7);
		rc("mask", 5'h10, 32'h7);
		// good transmits with random bytes
		for (int k = 0; k < 3; k++)
		begin
			v = xs();
			bw(5'h04, 32'h3);
			bus(1'h1, 5'h00, v, 4'h0);
			rc("stat_be0", 5'h08, 32'h10);
			bw(5'h00, v);
			@(posedge clk_i);
			check("tx_load", {31'h0, txl}, 32'h1);
			check("tx_data", {24'h0, txd}, {24'h0, v[7:0]});
			rc("stat_busy", 5'h08, 32'h0);
			ps2s_peer_inst.pulse(11, 100, 11'h7FF);
			cyc(6);
			rc("stat_done", 5'h08, 32'h10);
			rc("ctrl_done", 5'h04, 32'h2);
			check("irq", {31'h0, irq}, 32'h1);
			rc("int", 5'h0C, 32'h1);
			cyc(1);
			check("irq_clr", {31'h0, irq}, 32'h0);
		end
		$display("test transmit done");
		// late start, bit gap, long frame
		for (int m = 0; m < 3; m++)
		begin
			ex = (m == 0) ? 32'hB0 : 32'h30;
			bw(5'h04, 32'h3);
			bw(5'h00, xs());
			if (m == 1)
				ps2s_peer_inst.pulse(3, 100, 11'h7FF);
			// slow frame: 200 ns clocks spaced just inside the bit gap limit
			if (m == 2)
				repeat (11)
				begin
					ps2s_peer_inst.pulse(1, 100, 11'h7FF);
					cyc(GAP - 20);
				end
			cyc((m == 0) ? LATE + 20 : GAP + 20);
			check("hold", {31'h0, clk_oe}, 32'h1);
			check("clk_o", {31'h0, clk_o}, 32'h0);
			rc("stat_to", 5'h08, ex);
			rc("ctrl_to", 5'h04, 32'h2);
			bw(5'h04, 32'h3);
			rc("ctrl_forced", 5'h04, 32'h2);
			bw(5'h08, 32'h0);
			rc("stat_w0", 5'h08, ex);
			bw(5'h08, ex & 32'hA0);
			rc("stat_w1c", 5'h08, 32'h10);
			cyc(HOLD + 4);
			check("hold_off", {31'h0, clk_oe}, 32'h0);
			bus(1'h0, 5'h0C, 32'h0, 4'hF);
		end
		$display("test timeouts done");
		// control clears end a transmit
		for (int m = 0; m < 2; m++)
		begin
			bw(5'h04, 32'h3);
			bw(5'h00, xs());
			bw(5'h04, (m == 0) ? 32'h2 : 32'h1);
			rc("stat_ctl", 5'h08, 32'h10);
			rc("int_ctl", 5'h0C, 32'h1);
		end
		$display("test control done");
		// receive with each stop setting and stop level
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 2; s++)
			begin
				v = xs();
				// random parity setting is only stored and passed on
				bw(5'h04, {26'h0, c[1:0], v[9:8], 2'h2});
				rc("ctrl_rx", 5'h04, {26'h0, c[1:0], v[9:8], 2'h2});
				check("ctrl_o", {26'h0, ctrl}, {26'h0, c[1:0], v[9:8], 2'h2});
				e = stop_bad(c[1:0], s[0]);
				fork
					ps2s_peer_inst.pulse(11, 100, frame_bits(v[7:0], s[0]));
					begin
						cyc(40);
						rc("rx_busy", 5'h08, 32'h50);
					end
				join
				cyc(10);
				check("rx_hold", {31'h0, clk_oe}, {31'h0, e});
				check("rx_irq", {31'h0, irq}, {31'h0, e});
				rc("rx_stat", 5'h08, e ? 32'h1A : 32'h10);
				rc("rx_int", 5'h0C, e ? 32'h6 : 32'h0);
				bw(5'h08, 32'h0A);
				cyc(HOLD + 4);
				check("rx_free", {31'h0, clk_oe}, 32'h0);
				rc("rx_clr", 5'h08, 32'h10);
			end
		$display("test receive done");
		// a fault that arrives while the clock enable is low is not seen
		ce <= 1'h0;
		fault <= 1'h1;
		@(posedge clk_i);
		fault <= 1'h0;
		cyc(3);
		check("ce_frozen", {31'h0, clk_oe}, 32'h0);
		ce <= 1'h1;
		rc("ce_stat", 5'h08, 32'h10);
		// masked fault from the shifter
		bw(5'h10, 32'h0);
		fault <= 1'h1;
		@(posedge clk_i);
		fault <= 1'h0;
		cyc(3);
		check("irq_mask", {31'h0, irq}, 32'h0);
		check("fault_hold", {31'h0, clk_oe}, 32'h1);
		rc("fault_stat", 5'h08, 32'h12);
		rc("fault_int", 5'h0C, 32'h2);
		$display("test fault done");
		results();
	end
endmodule
